// *** design/tmr_compare_top.sv ***
// 8-bit timer/counter with two compare channels, normal and clear-on-match modes
// assumes: control bits come from same-clock register logic; ext_clk_pin is a raw pin
// What this block does
// - in non-pwm modes a force strobe acts as a match for that channel
// - forced match skips flag and counter clear, but updates output state
// - counter write suppresses both channels' compare matches, but not the clear-on-match counter clear, in the following timer tick
// - output state bits keep their value across waveform mode changes
// - action field is unbuffered; new value governs the very next match
// - reset clears each channel output state to zero
// - nonzero action field routes output state to pin; direction bit gates driving
// - pin override works the same in every waveform mode
// - action value zero leaves output state unchanged on match
// - counting depends on waveform select only, never on action field
// - action sets, clears or toggles on a match in pwm and non-pwm modes alike
// - waveform select zero counts up, never clears, wraps ff to 00
// - normal mode sets overflow flag in the tick counter becomes zero
// - normal mode accepts counter writes at any time
// - waveform select two clears counter on match with compare value a
// - clear-on-match compare a writes are direct; low value wraps through ff
// - clear-on-match sets compare flag a each time top is reached, except at top in the timer tick after a counter write
// - action one in clear-on-match toggles output a on each match
// - prescaler divides by 1, 8, 64, 256 or 1024
// - clear-on-match sets overflow flag when counter passes ff to zero
// - match sets compare flag next tick; service or write-one clears it
// - counter write beats clear and count in the same cycle
// - clock select zero stops the counter; still readable and writable
// - compare writes go straight to the active compare register
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"

module tmr_compare_top #(
   parameter int PRESC_W = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control bits
   input wire tmr_pkg::tmr_ctrl_t ctrl,
   input wire logic [1:0] force_compare_strobe,
   // counter and compare writes
   input wire logic counter_write,
   input wire logic [7:0] counter_wdata,
   input wire logic [1:0] compare_write,
   input wire logic [7:0] compare_wdata,
   // flag clears, write-one or interrupt serviced
   input wire logic overflow_flag_clear,
   input wire logic [1:0] compare_match_flag_clear,
   // external timer clock pin
   input wire logic ext_clk_pin,
   // port pin side
   input wire logic [1:0] port_out_bit,
   input wire logic [1:0] pin_direction_bit,
   // state and pins
   output logic [7:0] counter_value,
   output logic [7:0] compare_value_a,
   output logic [7:0] compare_value_b,
   output tmr_pkg::tmr_flags_t flags,
   output logic [1:0] compare_output_state,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe_n
);

   // elaboration check: the prescaler must hold the widest tap
   generate
      if (PRESC_W < `TMR_DIV1024_BITS)
      begin : g_presc_too_narrow
         $error("prescaler too narrow for divide by 1024");
      end
   endgenerate

   // shared timer state
   logic [PRESC_W-1:0] presc_q;
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic blk_q;
   logic ovf_q;

   // per-channel state, gathered from the channel loop
   wire logic [7:0] ocr [2];
   wire logic [1:0] oc;
   wire logic [1:0] ocf;
   wire logic [1:0] pin;
   wire logic [1:0] oe_n;

   // timer clock selection
   wire logic [2:0] cs = ctrl.clock_source_select;
   wire logic ext_rise = ext_s2_q & ~ext_s3_q;
   wire logic ext_fall = ~ext_s2_q & ext_s3_q;
   wire logic tick =
      (cs == `TMR_CS_DIV1) |
      ((cs == `TMR_CS_DIV8) & (&presc_q[`TMR_DIV8_BITS-1:0])) |
      ((cs == `TMR_CS_DIV64) & (&presc_q[`TMR_DIV64_BITS-1:0])) |
      ((cs == `TMR_CS_DIV256) & (&presc_q[`TMR_DIV256_BITS-1:0])) |
      ((cs == `TMR_CS_DIV1024) & (&presc_q[`TMR_DIV1024_BITS-1:0])) |
      ((cs == `TMR_CS_EXT_FALL) & ext_fall) |
      ((cs == `TMR_CS_EXT_RISE) & ext_rise);

   // mode decode, waveform select only
   wire logic [2:0] wgm = ctrl.waveform_generation_select;
   wire logic non_pwm = ~wgm[0];
   wire logic ctc_mode = (wgm == `TMR_WGM_CTC);
   wire logic top_hit = ctc_mode & (cnt_q == ocr[0]);
   wire logic wrap = (cnt_q == `TMR_CNT_MAX);
   wire logic ovf_set = tick & ~counter_write & wrap;
   wire logic blk_d = counter_write | (blk_q & ~tick);
   wire logic [1:0] com [2];
   assign com[0] = ctrl.compare_output_action_a;
   assign com[1] = ctrl.compare_output_action_b;

   // counter next value
   always_comb
   begin
      cnt_d = cnt_q;
      if (counter_write)
      begin
         cnt_d = counter_wdata;
      end
      else if (tick)
      begin
         if (top_hit)
         begin
            cnt_d = `TMR_CNT_BOTTOM;
         end
         else
         begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   function automatic logic oc_next(input logic [1:0] act, input logic oc);
      case (act)
         `TMR_COM_TOGGLE: oc_next = ~oc;
         `TMR_COM_CLEAR: oc_next = 1'b0;
         `TMR_COM_SET: oc_next = 1'b1;
         default: oc_next = oc;
      endcase
   endfunction

   // free-running prescaler
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         presc_q <= '0;
      end
      else
      begin
         presc_q <= presc_q + {{(PRESC_W-1){1'h0}}, 1'h1};
      end
   end

   // external clock pin: two sync flops, then one edge flop
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ext_s1_q <= 1'h0;
         ext_s2_q <= 1'h0;
         ext_s3_q <= 1'h0;
      end
      else
      begin
         ext_s1_q <= ext_clk_pin;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // counter register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_q <= `TMR_CNT_RST;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   // compare block after a counter write, held until a timer tick
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         blk_q <= 1'h0;
      end
      else
      begin
         blk_q <= blk_d;
      end
   end

   // overflow flag, set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ovf_q <= 1'h0;
      end
      else
      begin
         ovf_q <= ovf_set | (ovf_q & ~overflow_flag_clear);
      end
   end

   // per-channel compare, flag, output state and pin override
   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_ch
         logic [7:0] ocr_q;
         logic pend_q;
         logic ocf_q;
         logic oc_q;
         logic pin_q;
         logic oe_n_q;
         wire logic match = tick & ~blk_q & (cnt_q == ocr_q);
         wire logic forced = force_compare_strobe[i] & non_pwm;
         wire logic act = match | forced;
         wire logic override = |com[i];
         wire logic flag_set = tick & pend_q;
         wire logic oc_d = act ? oc_next(com[i], oc_q) : oc_q;

         // compare value, written straight through
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               ocr_q <= `TMR_OCR_RST;
            end
            else if (compare_write[i])
            begin
               ocr_q <= compare_wdata;
            end
         end

         // a match seen on one tick raises the flag on the next tick
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               pend_q <= 1'h0;
            end
            else if (tick)
            begin
               pend_q <= match;
            end
         end

         // compare flag, set wins over a clear in the same cycle
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               ocf_q <= 1'h0;
            end
            else
            begin
               ocf_q <= flag_set | (ocf_q & ~compare_match_flag_clear[i]);
            end
         end

         // output state, kept across mode changes
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               oc_q <= `TMR_OC_RST;
            end
            else
            begin
               oc_q <= oc_d;
            end
         end

         // pin level and enable, low enable drives
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               pin_q <= 1'h0;
               oe_n_q <= 1'h1;
            end
            else
            begin
               pin_q <= override ? oc_q : port_out_bit[i];
               oe_n_q <= ~pin_direction_bit[i];
            end
         end

         assign ocr[i] = ocr_q;
         assign oc[i] = oc_q;
         assign ocf[i] = ocf_q;
         assign pin[i] = pin_q;
         assign oe_n[i] = oe_n_q;
      end
   endgenerate

   assign counter_value = cnt_q;
   assign compare_value_a = ocr[0];
   assign compare_value_b = ocr[1];
   assign flags.overflow_flag = ovf_q;
   assign flags.compare_match_flag = ocf;
   assign compare_output_state = oc;
   assign pin_out = pin;
   assign pin_oe_n = oe_n;

endmodule

`default_nettype wire

// *** design/tmr_regs.svh ***
// reset values, mode codes and prescaler masks of the 8-bit compare timer
// assumes: included by bare name from design files
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

`define TMR_CNT_RST 8'h00
`define TMR_OCR_RST 8'h00
`define TMR_OC_RST 1'h0
`define TMR_CNT_MAX 8'hFF
`define TMR_CNT_BOTTOM 8'h00
`define TMR_WGM_NORMAL 3'h0
`define TMR_WGM_CTC 3'h2
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7
`define TMR_COM_KEEP 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3
`define TMR_PRESC_RST 10'h000
`define TMR_DIV8_BITS 3
`define TMR_DIV64_BITS 6
`define TMR_DIV256_BITS 8
`define TMR_DIV1024_BITS 10

`endif

// *** design/tmr_pkg.sv ***
// types shared by the 8-bit compare timer
// assumes: compiled before the timer module
package tmr_pkg;

   // software control bits
   typedef struct packed {
      logic [2:0] clock_source_select;
      logic [2:0] waveform_generation_select;
      logic [1:0] compare_output_action_b;
      logic [1:0] compare_output_action_a;
   } tmr_ctrl_t;

   // sticky status flags
   typedef struct packed {
      logic overflow_flag;
      logic [1:0] compare_match_flag;
   } tmr_flags_t;

endpackage

// *** verification/tmr_compare_props.sv ***
// port assertions for the compare timer
// assumes: bound to tmr_compare_top, one clock
`timescale 1ns/1ns
`default_nettype none
module tmr_compare_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // inputs
   input wire tmr_pkg::tmr_ctrl_t ctrl,
   input wire logic [1:0] force_compare_strobe,
   input wire logic counter_write,
   input wire logic [7:0] counter_wdata,
   // outputs
   input wire logic [7:0] counter_value,
   input wire logic [7:0] compare_value_a,
   input wire tmr_pkg::tmr_flags_t flags,
   input wire logic [1:0] compare_output_state,
   input wire logic [1:0] pin_out
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   wire every = ctrl.clock_source_select == 3'h1 && !counter_write;
   wire [1:0] act = ctrl.compare_output_action_a;
   wire [2:0] wgm = ctrl.waveform_generation_select;
   chk_reset_clear: assert property (disable iff (1'b0) rst |=> compare_output_state == 2'h0)
      else $error("output state not cleared");
   chk_pin_override: assert property (act != 2'h0 |=> pin_out[0] == $past(compare_output_state[0]))
      else $error("pin not driven from output state");
   chk_action_keep: assert property (act == 2'h0 |=> $stable(compare_output_state[0]))
      else $error("output state moved with action zero");
   chk_force_level: assert property (force_compare_strobe[0] && !wgm[0] && act[1]
      |=> compare_output_state[0] == $past(act[0]))
      else $error("forced match gave wrong level");
   chk_overflow_set: assert property (every && counter_value == 8'hFF |=> flags.overflow_flag)
      else $error("overflow flag not set");
   chk_ctc_clear: assert property (every && wgm == 3'h2 && counter_value == compare_value_a
      |=> counter_value == 8'h00)
      else $error("counter not cleared on match");
   chk_count_up: assert property (every && wgm == 3'h0 |=> counter_value == 8'($past(counter_value) + 8'h01))
      else $error("counter did not increment");
   chk_write_wins: assert property (counter_write |=> counter_value == $past(counter_wdata))
      else $error("counter write lost");
   cover property (force_compare_strobe[0]);
   cover property (flags.overflow_flag);
   cover property (flags.compare_match_flag[0]);
endmodule
bind tmr_compare_top tmr_compare_props u_tmr_compare_props (.clk(clk), .rst(rst), .ctrl(ctrl),
   .force_compare_strobe(force_compare_strobe), .counter_write(counter_write),
   .counter_wdata(counter_wdata), .counter_value(counter_value),
   .compare_value_a(compare_value_a), .flags(flags),
   .compare_output_state(compare_output_state), .pin_out(pin_out));
`default_nettype wire

// *** verification/tmr_pin_model.sv ***
// port pin seen from outside
// assumes: pin_oe_n low while the timer drives
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_model (
   // pin side
   input wire logic clk,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe_n,
   // level on the wire
   output logic [1:0] pin_level
);
   logic [1:0] last_q = 2'h0;
   always @(posedge clk)
   begin
      last_q <= pin_level;
   end
   // released pin floats: show a changing level
   assign pin_level = (pin_out & ~pin_oe_n) | (~last_q & pin_oe_n);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the compare timer
// assumes: design, checker and pin model compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   tmr_pkg::tmr_ctrl_t ctrl = '0;
   logic [1:0] fcs = 2'h0, cmw = 2'h0, pob = 2'h0, pdb = 2'h0;
   logic cw = 1'b0, ofc = 1'b0;
   logic ext = 1'b0;
   logic [1:0] mfc = 2'h0;
   logic [7:0] cwd = 8'h00, mwd = 8'h00, cnt;
   logic [7:0] cva, cvb;
   logic [1:0] oc, po, oen, lvl;
   tmr_pkg::tmr_flags_t fl;
   int err_total = 0;
   int checks_done = 0;
   always #50 clk = ~clk;
   tmr_compare_top u_tmr_compare_top (.clk(clk), .rst(rst), .ctrl(ctrl),
      .force_compare_strobe(fcs), .counter_write(cw), .counter_wdata(cwd),
      .compare_write(cmw), .compare_wdata(mwd), .overflow_flag_clear(ofc),
      .compare_match_flag_clear(mfc), .ext_clk_pin(ext), .port_out_bit(pob),
      .pin_direction_bit(pdb), .counter_value(cnt), .compare_value_a(cva),
      .compare_value_b(cvb), .flags(fl), .compare_output_state(oc), .pin_out(po),
      .pin_oe_n(oen));
   tmr_pin_model u_tmr_pin_model (.clk(clk), .pin_out(po), .pin_oe_n(oen), .pin_level(lvl));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmpv(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected at %0t: %h not %h", $time, g, e);
      end
   endtask
   task automatic cmpb(input logic g, input logic e);
      cmpv({7'h00, g}, {7'h00, e});
   endtask
   task automatic wr_cnt(input logic [7:0] v);
      cwd = v;
      cw = 1'b1;
      step(1);
      cw = 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (1000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   initial
   begin
      step(20);
      rst = 1'b0;
      cmpb(oc[0], 1'b0);
      ctrl.clock_source_select = 3'h1;
      wr_cnt(8'hFE);
      cmpv(cnt, 8'hFE);
      step(2);
      ctrl.clock_source_select = 3'h0;
      cmpv(cnt, 8'h00);
      cmpb(fl.overflow_flag, 1'b1);
      cmpv({6'h00, fl.compare_match_flag}, 8'h03);
      ofc = 1'b1;
      mfc = 2'h3;
      step(1);
      ofc = 1'b0;
      mfc = 2'h0;
      step(2);
      cmpb(fl.overflow_flag, 1'b0);
      cmpv({6'h00, fl.compare_match_flag}, 8'h00);
      cmpv(cnt, 8'h00);
      // actions 3,2,1,1,0 forced in turn
      for (int i = 0; i < 5; i++)
      begin
         ctrl.compare_output_action_a = 2'(10'h05B >> (2 * i));
         ctrl.compare_output_action_b = 2'(10'h05B >> (2 * i));
         fcs = 2'h3;
         step(1);
         fcs = 2'h0;
         cmpb(oc[0], 1'(5'h05 >> i));
         cmpb(oc[1], 1'(5'h05 >> i));
         cmpv({6'h00, fl.compare_match_flag}, 8'h00);
         step(1);
      end
      cmpv(cnt, 8'h00);
      pob = 2'h1;
      pdb = 2'h1;
      step(1);
      cmpb(lvl[0], 1'b1);
      ctrl.compare_output_action_a = 2'h2;
      step(1);
      cmpb(lvl[0], 1'b0);
      ctrl.waveform_generation_select = 3'h2;
      step(1);
      cmpb(oc[0], 1'b0);
      mwd = 8'h03;
      cmw = 2'h3;
      step(1);
      cmw = 2'h0;
      cmpv(cva, 8'h03);
      cmpv(cvb, 8'h03);
      ctrl.clock_source_select = 3'h1;
      ctrl.compare_output_action_a = 2'h1;
      wr_cnt(8'h03);
      step(2);
      cmpb(fl.compare_match_flag[0], 1'b0);
      cmpb(oc[0], 1'b0);
      step(3);
      cmpv(cnt, 8'h00);
      cmpb(oc[0], 1'b1);
      step(1);
      cmpb(fl.compare_match_flag[0], 1'b1);
      step(3);
      cmpb(oc[0], 1'b0);
      ctrl.compare_output_action_a = 2'h2;
      step(4);
      cmpb(oc[0], 1'b0);
      ctrl = '0;
      wr_cnt(8'h10);
      ctrl.clock_source_select = 3'h2;
      step(16);
      ctrl.clock_source_select = 3'h7;
      cmpv(cnt, 8'h12);
      ext = 1'b1;
      step(4);
      cmpv(cnt, 8'h13);
      ext = 1'b0;
      step(4);
      cmpv(cnt, 8'h13);
      print_verdict();
   end
endmodule
`default_nettype wire
